// File: verilog/sdl_loader.sv
// start-up default loader, register file and bus power path gating
//
// What this block does
// - every power-up and pin reset copies defaults into the registers, non-volatile ones for memory-backed slots, fixed ones for software-only slots
// - software writes hold until rewritten, power cycle or reset
// - default reprogramming needs the customer password; new values load at reset
// - parameters are software-only, memory-only, or both
// - cable-supply level select defaults 0, cable-supply monitoring enable defaults 1
// - low bus margin shift defaults to 0101b
// - power-up load starts at internal power-on reset release
// - reset-pin load starts at release of the reset pin
// - low-voltage supply used when above 3.1 V, else high-voltage supply
// - with undervolt check on, path needs high supply above its threshold when high supply is present
// - window check off swaps valid range for bus undervolt condition
// - safe-zero select 00,01,10,11 gives 0.6, 0.9, 1.2, 1.8 V
// - software reset acts like reset pin but keeps register values
`default_nettype none
module sdl_loader (
    // clock and power-on reset
    input wire logic clk,
    input wire logic resetn,
    // reset pin, active low
    input wire logic reset_pin_n,
    // register access from the serial engine
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic load_done,
    // non-volatile memory read port
    output logic nvm_rd_req,
    output logic [3:0] nvm_addr,
    input wire logic nvm_rd_valid,
    input wire logic [7:0] nvm_rdata,
    // non-volatile memory programming
    input wire logic prog_req,
    input wire logic [15:0] prog_password,
    input wire logic [3:0] prog_addr,
    input wire logic [7:0] prog_data,
    output logic nvm_wr_en,
    output logic [3:0] nvm_wr_addr,
    output logic [7:0] nvm_wr_data,
    // supplies
    input wire logic lv_supply_present,
    input wire logic lv_supply_above_3v1,
    output logic low_voltage_system_supply,
    // power path conditions and open-drain enable pin
    input wire sdl_pkg::sdl_cond_t cond,
    output logic bus_power_path_enable_n_o,
    output logic bus_power_path_enable_n_oe,
    // configuration
    output var sdl_pkg::sdl_cfg_t cfg,
    output logic [4:0] safe_zero_level_dv
);
    import sdl_pkg::*;

    // ----------------------------------------------------------------
    // loader state
    // ----------------------------------------------------------------
    sdl_state_t state;
    logic [3:0] slot;
    logic [7:0] nvm_only;
    logic [7:0] regs [SDL_SLOTS];
    logic [SDL_SLOTS-1:0] hit;
    logic [SDL_SLOTS-1:0] slot_load;
    logic slot_is_nvm;
    logic load_fire;
    logic [7:0] load_data;
    logic last_slot;
    logic wr_ok;
    logic sw_reset;
    logic path_ok;
    logic hv_ok;
    logic bus_ok;
    logic [7:0] read_mux;

    assign slot_is_nvm = SDL_SLOT_NVM[slot];
    assign last_slot = (slot == SDL_NVM_ONLY_SLOT);
    // software-only slots take their fixed default, others the fetched word
    assign load_fire = (state == SDL_FETCH && !slot_is_nvm) ||
        (state == SDL_WAIT && nvm_rd_valid);
    assign load_data = slot_is_nvm ? nvm_rdata : SDL_SLOT_RESET[slot[2:0]];
    assign nvm_rd_req = (state == SDL_FETCH) && slot_is_nvm;
    assign nvm_addr = slot;
    assign load_done = (state == SDL_DONE);

    // sequencer: pin hold, then one slot after another
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= SDL_HOLD;
            slot <= 4'h0;
        end else if (!reset_pin_n) begin
            state <= SDL_HOLD;
            slot <= 4'h0;
        end else begin
            case (state)
                SDL_HOLD: begin
                    state <= SDL_FETCH;
                end
                SDL_FETCH: begin
                    if (slot_is_nvm) begin
                        state <= SDL_WAIT;
                    end else begin
                        slot <= slot + 4'h1;
                    end
                end
                SDL_WAIT: begin
                    if (nvm_rd_valid) begin
                        if (last_slot) begin
                            state <= SDL_DONE;
                        end else begin
                            state <= SDL_FETCH;
                            slot <= slot + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= SDL_DONE;
                end
            endcase
        end
    end

    // word with no register location
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nvm_only <= SDL_NVM_ONLY_RESET;
        end else if (load_fire && last_slot) begin
            nvm_only <= load_data;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    assign wr_ok = reg_wr_en && load_done && reset_pin_n;
    genvar gi;
    generate
        for (gi = 0; gi < SDL_SLOTS; gi++) begin : g_slot
            assign hit[gi] = (reg_addr == SDL_SLOT_ADDR[gi]);
            assign slot_load[gi] = load_fire && (slot == 4'(gi));
            sdl_cfg_reg #(
                .RESET_VAL(SDL_SLOT_RESET[gi]),
                .WMASK(SDL_SLOT_WMASK[gi])
            ) u_reg (
                .clk(clk),
                .resetn(resetn),
                .load_en(slot_load[gi]),
                .load_data(load_data),
                .wr_en(wr_ok && hit[gi]),
                .wr_data(reg_wdata),
                .value(regs[gi])
            );
        end
    endgenerate

    // read selection; unmapped addresses read zero
    always_comb begin
        read_mux = 8'h00;
        if (reg_addr == SDL_ADDR_PATH_STATUS) begin
            read_mux = {7'h00, bus_power_path_enable_n_oe};
        end else begin
            for (int i = 0; i < SDL_SLOTS; i++) begin
                if (hit[i]) begin
                    read_mux = regs[i];
                end
            end
        end
    end

    // read data register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rdata <= read_mux;
        end
    end

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    assign cfg.attach_change_alert_mask = regs[0][SDL_ALERT_ATTACH_BIT];
    assign cfg.monitor_change_alert_mask = regs[0][SDL_ALERT_MON_BIT];
    assign cfg.fault_alert_mask = regs[0][SDL_ALERT_FAULT_BIT];
    assign cfg.cable_discharge_en = regs[1][SDL_CABLE_DIS_BIT];
    assign cfg.cable_supply_en = regs[1][SDL_CABLE_EN_BIT];
    assign cfg.cable_switch_current_limit = regs[2][SDL_ILIM_LSB +: 4];
    assign cfg.cable_supply_monitor_en = regs[3][SDL_CMON_EN_BIT];
    assign cfg.cable_supply_low_level_select = regs[3][SDL_CMON_LEVEL_BIT];
    assign cfg.bus_high_margin_shift = regs[4][SDL_HIGH_SHIFT_LSB +: 4];
    assign cfg.bus_low_margin_shift = regs[4][SDL_LOW_SHIFT_LSB +: 4];
    assign cfg.software_reset_request = regs[5][SDL_SW_RESET_BIT];
    assign cfg.bus_discharge_duration = regs[6][SDL_DIS_TIME_LSB +: 4];
    assign cfg.supply_overvolt_check_off = regs[7][SDL_OVLO_OFF_BIT];
    assign cfg.bus_window_check_off = regs[7][SDL_WINDOW_OFF_BIT];
    assign cfg.safe_zero_level_select = regs[7][SDL_SAFE0_LSB +: 2];
    assign cfg.supply_undervolt_check_off = regs[7][SDL_UVLO_OFF_BIT];
    assign cfg.standby_power_off = nvm_only[SDL_STANDBY_OFF_BIT];
    assign cfg.bus_discharge_off = nvm_only[SDL_DISCHARGE_OFF_BIT];

    // ----------------------------------------------------------------
    // power path, supply choice, thresholds, programming
    // ----------------------------------------------------------------
    assign sw_reset = cfg.software_reset_request;
    assign hv_ok = !cond.hv_supplied ||
        ((cfg.supply_overvolt_check_off || !cond.hv_above_ovlo) &&
         (cfg.supply_undervolt_check_off || cond.hv_above_uvlo));
    assign bus_ok = cfg.bus_window_check_off ? cond.bus_above_uvlo : cond.bus_in_window;
    assign path_ok = load_done && !sw_reset && (cond.attached_src || cond.debug_acc_src) &&
        hv_ok && bus_ok;
    assign bus_power_path_enable_n_o = 1'b0;

    // registered outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_power_path_enable_n_oe <= 1'b0;
            low_voltage_system_supply <= 1'b0;
            safe_zero_level_dv <= SDL_SAFE0_DV[0];
            nvm_wr_en <= 1'b0;
            nvm_wr_addr <= 4'h0;
            nvm_wr_data <= 8'h00;
        end else begin
            bus_power_path_enable_n_oe <= path_ok;
            low_voltage_system_supply <= lv_supply_present && lv_supply_above_3v1;
            safe_zero_level_dv <= SDL_SAFE0_DV[cfg.safe_zero_level_select];
            nvm_wr_en <= prog_req && (prog_password == SDL_PASSWORD);
            nvm_wr_addr <= prog_addr;
            nvm_wr_data <= prog_data;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_path_needs_attach;
        @(posedge clk) disable iff (!resetn)
        !(cond.attached_src || cond.debug_acc_src) |=> !bus_power_path_enable_n_oe;
    endproperty
    a_path_needs_attach: assert property (p_path_needs_attach)
        else $error("power path enabled while not attached");

    property p_path_uvlo;
        @(posedge clk) disable iff (!resetn)
        (!cfg.supply_undervolt_check_off && cond.hv_supplied && !cond.hv_above_uvlo)
            |=> !bus_power_path_enable_n_oe;
    endproperty
    a_path_uvlo: assert property (p_path_uvlo)
        else $error("power path enabled with supply under threshold");

    property p_path_window;
        @(posedge clk) disable iff (!resetn)
        (cfg.bus_window_check_off ? !cond.bus_above_uvlo : !cond.bus_in_window)
            |=> !bus_power_path_enable_n_oe;
    endproperty
    a_path_window: assert property (p_path_window)
        else $error("power path enabled with bus condition failing");

    property p_no_write_while_loading;
        @(posedge clk) disable iff (!resetn)
        (!load_done && !load_fire && reg_wr_en) |=> $stable(cfg);
    endproperty
    a_no_write_while_loading: assert property (p_no_write_while_loading)
        else $error("register changed by a write before load complete");

    property p_pin_restarts_load;
        @(posedge clk) disable iff (!resetn)
        !reset_pin_n |=> !load_done ##1
            ($past(reset_pin_n) ? state == SDL_FETCH : !load_done);
    endproperty
    a_pin_restarts_load: assert property (p_pin_restarts_load)
        else $error("reset pin release did not restart the load");

    property p_sw_reset_keeps;
        @(posedge clk) disable iff (!resetn)
        (sw_reset && load_done && reset_pin_n) |=> load_done && !bus_power_path_enable_n_oe;
    endproperty
    a_sw_reset_keeps: assert property (p_sw_reset_keeps)
        else $error("software reset reloaded defaults or left path on");

    property p_monitor_default;
        @(posedge clk) disable iff (!resetn)
        (state == SDL_FETCH && slot == 4'h3 && reset_pin_n)
            |=> cfg.cable_supply_monitor_en && !cfg.cable_supply_low_level_select;
    endproperty
    a_monitor_default: assert property (p_monitor_default)
        else $error("cable-supply monitor default not loaded");

    property p_password;
        @(posedge clk) disable iff (!resetn)
        (prog_req && prog_password != SDL_PASSWORD) |=> !nvm_wr_en;
    endproperty
    a_password: assert property (p_password)
        else $error("programming without valid password");

    property p_safe_zero;
        @(posedge clk) disable iff (!resetn)
        (cfg.safe_zero_level_select == 2'h3) |=> (safe_zero_level_dv == 5'h12);
    endproperty
    a_safe_zero: assert property (p_safe_zero)
        else $error("safe-zero code 11 not 1.8 V");

    property p_supply_select;
        @(posedge clk) disable iff (!resetn)
        (lv_supply_present && !lv_supply_above_3v1) |=> !low_voltage_system_supply;
    endproperty
    a_supply_select: assert property (p_supply_select)
        else $error("low-voltage supply chosen below 3.1 V");

    property p_write_holds;
        @(posedge clk) disable iff (!resetn)
        (load_done && reset_pin_n && !reg_wr_en) |=> $stable(cfg);
    endproperty
    a_write_holds: assert property (p_write_holds)
        else $error("configuration changed without a write");
endmodule // sdl_loader
`default_nettype wire

// File: verilog/sdl_pkg.sv
// constants, register map and carrier types of the start-up default loader
`default_nettype none
package sdl_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int SDL_SLOTS = 8;
    localparam logic [7:0] SDL_ADDR_ALERT_MASK = 8'h0C;
    localparam logic [7:0] SDL_ADDR_CABLE_CTRL = 8'h18;
    localparam logic [7:0] SDL_ADDR_CABLE_ILIM = 8'h1E;
    localparam logic [7:0] SDL_ADDR_CABLE_MON = 8'h20;
    localparam logic [7:0] SDL_ADDR_MARGIN = 8'h22;
    localparam logic [7:0] SDL_ADDR_SW_RESET = 8'h23;
    localparam logic [7:0] SDL_ADDR_DISCHARGE = 8'h25;
    localparam logic [7:0] SDL_ADDR_PATH_STATUS = 8'h27;
    localparam logic [7:0] SDL_ADDR_BUS_MON = 8'h2E;
    // slot order of the register file and of the non-volatile words
    localparam logic [7:0] SDL_SLOT_ADDR [SDL_SLOTS] = '{
        SDL_ADDR_ALERT_MASK, SDL_ADDR_CABLE_CTRL, SDL_ADDR_CABLE_ILIM, SDL_ADDR_CABLE_MON,
        SDL_ADDR_MARGIN, SDL_ADDR_SW_RESET, SDL_ADDR_DISCHARGE, SDL_ADDR_BUS_MON};
    // factory defaults, also the value held until the load overwrites it
    localparam logic [7:0] SDL_SLOT_RESET [SDL_SLOTS] = '{
        8'h70, 8'h02, 8'h00, 8'h02, 8'h55, 8'h00, 8'h6F, 8'h01};
    // bits software may write; the others read their reset value
    localparam logic [7:0] SDL_SLOT_WMASK [SDL_SLOTS] = '{
        8'h70, 8'h03, 8'hF0, 8'h03, 8'hFF, 8'h01, 8'hF0, 8'h57};
    // slot fetched from non-volatile memory (1) or software-only (0); bit 8 is the
    // word with no register location
    localparam logic [8:0] SDL_SLOT_NVM = 9'h1D7;
    localparam logic [3:0] SDL_NVM_ONLY_SLOT = 4'h8;
    localparam logic [7:0] SDL_NVM_ONLY_RESET = 8'h01;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SDL_ALERT_ATTACH_BIT = 6;
    localparam int SDL_ALERT_MON_BIT = 5;
    localparam int SDL_ALERT_FAULT_BIT = 4;
    localparam int SDL_CABLE_DIS_BIT = 0;
    localparam int SDL_CABLE_EN_BIT = 1;
    localparam int SDL_ILIM_LSB = 4;
    localparam int SDL_CMON_LEVEL_BIT = 0;
    localparam int SDL_CMON_EN_BIT = 1;
    localparam int SDL_HIGH_SHIFT_LSB = 4;
    localparam int SDL_LOW_SHIFT_LSB = 0;
    localparam int SDL_SW_RESET_BIT = 0;
    localparam int SDL_DIS_TIME_LSB = 4;
    localparam int SDL_OVLO_OFF_BIT = 6;
    localparam int SDL_WINDOW_OFF_BIT = 4;
    localparam int SDL_SAFE0_LSB = 1;
    localparam int SDL_UVLO_OFF_BIT = 0;
    localparam int SDL_STANDBY_OFF_BIT = 0;
    localparam int SDL_DISCHARGE_OFF_BIT = 1;
    // safe-zero threshold in tenths of a volt per select code
    localparam logic [4:0] SDL_SAFE0_DV [4] = '{5'h06, 5'h09, 5'h0C, 5'h12};
    // arbitrary value, replace per product
    localparam logic [15:0] SDL_PASSWORD = 16'hA5C3;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SDL_HOLD, SDL_FETCH, SDL_WAIT, SDL_DONE} sdl_state_t;
    typedef struct packed {
        logic attach_change_alert_mask;
        logic monitor_change_alert_mask;
        logic fault_alert_mask;
        logic cable_discharge_en;
        logic cable_supply_en;
        logic [3:0] cable_switch_current_limit;
        logic cable_supply_monitor_en;
        logic cable_supply_low_level_select;
        logic [3:0] bus_high_margin_shift;
        logic [3:0] bus_low_margin_shift;
        logic software_reset_request;
        logic [3:0] bus_discharge_duration;
        logic supply_overvolt_check_off;
        logic bus_window_check_off;
        logic [1:0] safe_zero_level_select;
        logic supply_undervolt_check_off;
        logic standby_power_off;
        logic bus_discharge_off;
    } sdl_cfg_t;
    typedef struct packed {
        logic attached_src;
        logic debug_acc_src;
        logic hv_supplied;
        logic hv_above_ovlo;
        logic hv_above_uvlo;
        logic bus_in_window;
        logic bus_above_uvlo;
    } sdl_cond_t;
endpackage
`default_nettype wire

// File: verilog/sdl_cfg_reg.sv
// one configuration register with default load and software write
`default_nettype none
module sdl_cfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // default load
    input wire logic load_en,
    input wire logic [7:0] load_data,
    // software write
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // value
    output logic [7:0] value
);
    logic [7:0] stored;

    // load wins over a write in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stored <= RESET_VAL;
        end else if (load_en) begin
            stored <= load_data;
        end else if (wr_en) begin
            stored <= wr_data;
        end
    end

    // fixed bits always read their reset value
    assign value = (stored & WMASK) | (RESET_VAL & ~WMASK);
endmodule // sdl_cfg_reg
`default_nettype wire

// File: test/sdl_nvm_model.sv
// behavioural non-volatile memory that answers the loader's fetches
`default_nettype none
module sdl_nvm_model (
    // clock, reset and pace
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    // read port
    input wire logic nvm_rd_req,
    input wire logic [3:0] nvm_addr,
    output logic nvm_rd_valid,
    output logic [7:0] nvm_rdata,
    // programming port
    input wire logic nvm_wr_en,
    input wire logic [3:0] nvm_wr_addr,
    input wire logic [7:0] nvm_wr_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import sdl_pkg::*;
    logic [7:0] mem [9];
    logic [2:0] wait_cnt;
    logic busy;
    // contents survive every reset; slot 0 and the memory-only word differ from
    // factory to prove the load
    initial begin
        for (int i = 0; i < SDL_SLOTS; i++) begin
            mem[i] = SDL_SLOT_RESET[i];
        end
        mem[0] = 8'h30;
        mem[8] = 8'h02;
    end
    // answer after one or four cycles; data toggles outside valid
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            wait_cnt <= 3'h0;
            nvm_rd_valid <= 1'b0;
            nvm_rdata <= 8'h5A;
        end else begin
            nvm_rd_valid <= 1'b0;
            nvm_rdata <= ~nvm_rdata;
            if (nvm_rd_req) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 3'h4 : 3'h1;
            end else if (busy && wait_cnt == 3'h1) begin
                busy <= 1'b0;
                nvm_rd_valid <= 1'b1;
                nvm_rdata <= mem[nvm_addr];
            end else if (busy) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
            if (nvm_wr_en) begin
                mem[nvm_wr_addr] <= nvm_wr_data;
            end
        end
    end
endmodule // sdl_nvm_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench of the start-up default loader
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sdl_pkg::*;
    logic clk, resetn, reset_pin_n, slow, reg_wr_en, reg_rd_en, prog_req;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, nvm_rdata, prog_data, nvm_wr_data;
    logic load_done, nvm_rd_req, nvm_rd_valid, nvm_wr_en, lv_present, lv_above, lv_sel;
    logic [3:0] nvm_addr, prog_addr, nvm_wr_addr;
    logic [15:0] prog_password;
    logic en_o, en_oe;
    logic [4:0] dv;
    sdl_cond_t cond;
    sdl_cfg_t cfg;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    sdl_loader dut (.clk(clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .load_done(load_done),
        .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr), .nvm_rd_valid(nvm_rd_valid),
        .nvm_rdata(nvm_rdata), .prog_req(prog_req), .prog_password(prog_password),
        .prog_addr(prog_addr), .prog_data(prog_data), .nvm_wr_en(nvm_wr_en),
        .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data),
        .lv_supply_present(lv_present), .lv_supply_above_3v1(lv_above),
        .low_voltage_system_supply(lv_sel), .cond(cond),
        .bus_power_path_enable_n_o(en_o), .bus_power_path_enable_n_oe(en_oe),
        .cfg(cfg), .safe_zero_level_dv(dv));
    sdl_nvm_model nvm (.clk(clk), .resetn(resetn), .slow(slow), .nvm_rd_req(nvm_rd_req),
        .nvm_addr(nvm_addr), .nvm_rd_valid(nvm_rd_valid), .nvm_rdata(nvm_rdata),
        .nvm_wr_en(nvm_wr_en), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wait_load();
        for (int n = 0; n < 300 && load_done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("load_done", load_done, 8'h01);
    endtask
    task automatic prog(logic [15:0] pw, logic [7:0] d);
        @(posedge clk);
        prog_req <= 1'b1;
        prog_password <= pw;
        prog_addr <= 4'h0;
        prog_data <= d;
        @(posedge clk);
        prog_req <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_powerup();
        for (int n = 0; n < 4 && nvm_rd_req !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("nvm_rd_req", nvm_rd_req, 8'h01);
        check("nvm_addr", nvm_addr, 8'h00);
        check("load_done", load_done, 8'h00);
        check("path_oe", en_oe, 8'h00);
        wait_load();
        for (int i = 0; i < SDL_SLOTS; i++) begin
            rd_chk(SDL_SLOT_ADDR[i], (i == 0) ? 8'h30 : SDL_SLOT_RESET[i]);
        end
        rd_chk(8'h01, 8'h00);
        check("cable_mon_en", cfg.cable_supply_monitor_en, 8'h01);
        check("cable_level", cfg.cable_supply_low_level_select, 8'h00);
        check("low_shift", cfg.bus_low_margin_shift, 8'h05);
        check("safe_zero_dv", dv, 8'h06);
        check("standby_off", cfg.standby_power_off, 8'h00);
        check("discharge_off", cfg.bus_discharge_off, 8'h01);
        rd_chk(8'h27, 8'h01);
    endtask
    task automatic t_keep();
        wr(8'h22, 8'h33);
        #1;
        check("low_shift", cfg.bus_low_margin_shift, 8'h03);
        rd_chk(8'h22, 8'h33);
        wr(8'h23, 8'h01);
        settle();
        check("path_oe", en_oe, 8'h00);
        rd_chk(8'h27, 8'h00);
        check("load_done", load_done, 8'h01);
        rd_chk(8'h22, 8'h33);
        wr(8'h23, 8'h00);
        slow <= 1'b1;
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_pin_n <= 1'b1;
        wr(8'h22, 8'h11);
        #1;
        check("load_done", load_done, 8'h00);
        wait_load();
        rd_chk(8'h22, 8'h55);
    endtask
    localparam logic [7:0] MON [11] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h00, 8'h00, 8'h10, 8'h10, 8'h40};
    localparam logic [6:0] CND [11] = '{7'h42, 7'h22, 7'h02, 7'h5A, 7'h52, 7'h41,
        7'h52, 7'h56, 7'h41, 7'h42, 7'h5E};
    localparam logic [10:0] EXP = 11'b10110010011;
    localparam logic [4:0] DV [4] = '{5'h06, 5'h09, 5'h0C, 5'h12};
    task automatic t_path();
        for (int i = 0; i < 11; i++) begin
            wr(8'h2E, MON[i]);
            cond <= CND[i];
            settle();
            check("path_oe", en_oe, EXP[i]);
        end
        check("path_drive", en_o, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h2E, {5'h00, c[1:0], 1'b1});
            settle();
            check("safe_zero_dv", dv, DV[c]);
        end
    endtask
    task automatic t_supply();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            lv_present <= i[1];
            lv_above <= i[0];
            settle();
            check("lv_select", lv_sel, (i == 3) ? 8'h01 : 8'h00);
        end
    endtask
    task automatic t_prog();
        prog(SDL_PASSWORD, 8'h50);
        prog(~SDL_PASSWORD, 8'h10);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        wait_load();
        rd_chk(8'h0C, 8'h50);
    endtask
    // ----------------------------------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {resetn, reset_pin_n, slow, reg_wr_en, reg_rd_en, prog_req} = 6'b010000;
        {reg_addr, reg_wdata, prog_data, prog_addr, prog_password} = '0;
        {lv_present, lv_above} = 2'b00;
        cond = 7'h42;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_powerup();
        t_keep();
        t_path();
        t_supply();
        t_prog();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
